// file: test/amcc_codec.sv
// codec stand-in: counts master clock edges it receives
`timescale 1ns/1ps
`default_nettype none
module amcc_codec
(
	input  wire logic        mclk,  // master clock
	input  wire logic        clr,   // clears count
	output logic      [15:0] edges  // rising edges
);
	always_ff @(posedge mclk or posedge clr)
	begin
		if (clr)
			edges <= 16'h0000;
		else
			edges <= edges + 16'h0001;
	end
endmodule : amcc_codec
`default_nettype wire

// file: test/amcc_core_asserts.sv
// port checks for the clock control block
`timescale 1ns/1ps
`default_nettype none
module amcc_chk
(
	input wire logic        pclk,                 // clock
	input wire logic        presetn,              // reset
	input wire logic        psel,                 // apb
	input wire logic        penable,              // apb
	input wire logic        pwrite,               // apb
	input wire logic [17:0] paddr,                // apb
	input wire logic [31:0] pwdata,               // apb
	input wire logic [3:0]  pstrb,                // apb
	input wire logic [31:0] prdata,               // apb
	input wire logic        pready,               // apb
	input wire logic        pslverr,              // apb
	input wire logic [23:0] synth_freq_word,      // word
	input wire logic        master_clock_out_one, // out one
	input wire logic        master_clock_out_two  // out two
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       wr;
	logic [7:0] ctl;
	logic [3:0] q1, q2, qd;
	assign wr = psel && penable && pready && pwrite && pstrb[0];
	function automatic logic [3:0] bump(input logic on, input logic [3:0] c);
		return on ? 4'h0 : c + {3'h0, c != 4'hf};
	endfunction : bump
	// cycles a gate bit has been clear; outputs lag the bit by a few flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl <= 8'h00;
			q1  <= 4'h0;
			q2  <= 4'h0;
			qd  <= 4'h0;
		end
		else
		begin
			if (wr && paddr == 18'h3ff84)
				ctl <= pwdata[7:0];
			q1 <= bump(ctl[6], q1);
			q2 <= bump(ctl[7], q2);
			qd <= bump(ctl[2], qd);
		end
	end
	freq_low_map_a:
	assert property (wr && paddr == 18'h3ffe4 |=> synth_freq_word[7:0] == $past(pwdata[7:0]))
		else $error("low byte");
	freq_mid_map_a:
	assert property (wr && paddr == 18'h3ffe0 |=> synth_freq_word[15:8] == $past(pwdata[7:0]))
		else $error("mid byte");
	freq_high_map_a:
	assert property (wr && paddr == 18'h3ffdc |=> synth_freq_word[23:16] == $past(pwdata[7:0]))
		else $error("high byte");
	word_reset_zero_a:
	assert property ($rose(presetn) |-> synth_freq_word == 24'h0) else $error("word reset");
	out_one_low_a:
	assert property (q1 > 4'h7 |-> !master_clock_out_one) else $error("out one ungated");
	out_two_low_a:
	assert property (q2 > 4'h7 |-> !master_clock_out_two) else $error("out two ungated");
	div_off_low_a:
	assert property (qd > 4'h7 |-> !master_clock_out_one && !master_clock_out_two)
		else $error("divider off");
	rsvd_read_zero_a:
	assert property (pready && !pwrite && !pslverr |-> prdata[31:8] == 24'h0
		&& (paddr != 18'h3ff84 || !prdata[5]) && (paddr != 18'h3ff88 || !prdata[3])
		&& (paddr != 18'h3ffd8 || prdata[3:0] == 4'h0)) else $error("reserved bit");
	cover property (wr && paddr == 18'h3ff84);
	cover property ($rose(master_clock_out_one));
	cover property (pready && pslverr);
endmodule : amcc_chk
bind amcc_core amcc_chk amcc_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .prdata, .pready, .pslverr, .synth_freq_word, .master_clock_out_one,
	.master_clock_out_two);
`default_nettype wire

// file: test/audio_master_clock_control_tb_top.sv
// self-checking bench for the audio master clock control block
`timescale 1ns/1ps
`default_nettype none
module audio_master_clock_control_tb_top;
	localparam int W = 2520; // window: multiple of every source period
	localparam logic [15:0] idx_tab [6] = '{16'hffe1, 16'hffe2, 16'hfff6,
		16'hfff7, 16'hfff8, 16'hfff9};
	localparam logic [7:0] msk_tab [6] = '{amcc_pkg::OUT_CTL_MASK,
		amcc_pkg::ONE_DIV_MASK, amcc_pkg::TWO_DIV_MASK, 8'hff, 8'hff, 8'hff};
	logic        pclk, presetn, psel, penable, pwrite, clr;
	logic        synth_one_clock, synth_two_clock, master_clock_in;
	logic        pready, pslverr, master_clock_out_one, master_clock_out_two;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic [23:0] synth_freq_word;
	logic [15:0] e1, e2;
	logic [7:0]  mdl [6];
	int          n_errors, tests_run;
	int          cyc = 0;
	amcc_core amcc_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .synth_one_clock, .synth_two_clock,
		.master_clock_in, .synth_freq_word, .master_clock_out_one, .master_clock_out_two);
	amcc_codec amcc_codec_i (.mclk(master_clock_out_one), .clr(clr), .edges(e1));
	amcc_codec amcc_codec_two_i (.mclk(master_clock_out_two), .clr(clr), .edges(e2));
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// sources kept slow: the block resynchronises them on pclk
	always @(posedge pclk)
	begin
		cyc             <= cyc + 1;
		synth_one_clock <= (cyc % 10) < 5;
		synth_two_clock <= (cyc % 14) < 7;
		master_clock_in <= (cyc % 18) < 9;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic chk_reg(input string nm, input logic [31:0] ex, input logic [31:0] got);
		tests_run++;
		if (got !== ex)
		begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, ex, got);
		end
	endtask : chk_reg
	task automatic chk_cnt(input string nm, input int ex, input logic [15:0] got);
		tests_run++;
		if (ex == 0 ? got !== 16'h0000
			: (got !== 16'(ex) && got !== 16'(ex + 1) && got !== 16'(ex - 1)))
		begin
			n_errors++;
			$display("BAD %s exp %0d got %0d", nm, ex, got);
		end
	endtask : chk_cnt
	task automatic apb(input logic wr, input logic [15:0] ix, input logic [7:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {ix, 2'b00};
		pwdata  <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 20)
		begin
			n_errors++;
			close_out();
		end
	endtask : apb
	task automatic measure();
		repeat (40) @(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (W) @(posedge pclk);
	endtask : measure
	function automatic int per(input logic [1:0] s, input logic [7:0] d1, input logic [7:0] d2);
		if (s[0])
			return 18 * (int'(d1[2:0]) + 1);
		if (s[1])
			return 14 * (int'(d2[7:4]) + 1);
		return 10 * (int'(d1[7:4]) + 1);
	endfunction : per
	initial
	begin
		logic [31:0] rd;
		logic        er;
		logic [7:0]  v, d1, d2;
		logic [1:0]  s1, s2;
		n_errors = 0;
		tests_run = 0;
		{presetn, psel, penable, pwrite, clr} = 5'h00;
		paddr = 18'h0;
		pwdata = 32'h0;
		pstrb = 4'hf;
		void'($urandom(32'he4d86548));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b0, idx_tab[i], 8'h00, rd, er);
			chk_reg("reset value", 32'h0, rd);
		end
		apb(1'b0, 16'hfff1, 8'h00, rd, er);
		chk_reg("unmapped error", 32'h1, {31'h0, er});
		apb(1'b0, 16'hfff0, 8'h00, rd, er);
		chk_reg("status reset", 32'h0, rd);
		$display("reset test done");
		for (int i = 0; i < 6; i++)
		begin
			v = 8'($urandom);
			mdl[i] = v & msk_tab[i];
			apb(1'b1, idx_tab[i], v, rd, er);
		end
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b0, idx_tab[i], 8'h00, rd, er);
			chk_reg("readback", {24'h0, mdl[i]}, rd);
		end
		chk_reg("freq word", {8'h0, mdl[3], mdl[4], mdl[5]}, {8'h0, synth_freq_word});
		pstrb <= 4'h0;
		apb(1'b1, idx_tab[5], ~mdl[5], rd, er);
		pstrb <= 4'hf;
		apb(1'b0, idx_tab[5], 8'h00, rd, er);
		chk_reg("strobe off", {24'h0, mdl[5]}, rd);
		$display("register test done");
		for (int i = 0; i < 4; i++)
		begin
			d1 = (i == 0) ? 8'h00 : (i == 3) ? 8'hf7 : 8'($urandom) & 8'hf7;
			d2 = (i == 0) ? 8'h00 : (i == 3) ? 8'hf0 : 8'($urandom) & 8'hf0;
			s1 = 2'(i);
			s2 = 2'(3 - i);
			apb(1'b1, 16'hffe2, d1, rd, er);
			apb(1'b1, 16'hfff6, d2, rd, er);
			apb(1'b1, 16'hffe1, {2'b11, 1'b0, s1, 1'b1, s2}, rd, er);
			measure();
			chk_cnt("out one edges", W / per(s1, d1, d2), e1);
			chk_cnt("out two edges", W / per(s2, d1, d2), e2);
		end
		$display("clock path test done");
		apb(1'b1, 16'hffe2, 8'h00, rd, er);
		apb(1'b1, 16'hffe1, 8'h84, rd, er);
		measure();
		chk_cnt("gated out one", 0, e1);
		chk_cnt("open out two", W / 10, e2);
		apb(1'b1, 16'hffe1, 8'hc0, rd, er);
		measure();
		chk_cnt("div off one", 0, e1);
		chk_cnt("div off two", 0, e2);
		$display("gating test done");
		close_out();
	end
endmodule : audio_master_clock_control_tb_top
`default_nettype wire

// file: verilog/amcc_core.sv
// audio master clock control: register file, dividers and output selection
//
// What this block does
// - holds a 24-bit synth_two frequency word across three byte registers.
// - low, mid, high bytes map to word bits 7:0, 15:8, 23:16; reset zero.
// - synth_two output divider divides by its 4-bit field plus one.
// - synth_one output divider divides by its 4-bit field plus one.
// - input clock divider divides by its 3-bit field plus one.
// - each master clock output toggles only when enabled, else held low.
// - reserved bits in divider and control registers read as zero.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none

module amcc_core
(
	input  wire logic                          pclk,                 // system clock
	input  wire logic                          presetn,              // async reset, active low
	input  wire logic                          psel,                 // apb select
	input  wire logic                          penable,              // apb enable
	input  wire logic                          pwrite,               // apb direction
	input  wire logic [amcc_pkg::ADDR_W-1:0]   paddr,                // apb byte address
	input  wire logic [amcc_pkg::DATA_W-1:0]   pwdata,               // apb write data
	input  wire logic [3:0]                    pstrb,                // apb byte strobes
	output logic      [amcc_pkg::DATA_W-1:0]   prdata,               // apb read data
	output logic                               pready,               // apb ready
	output logic                               pslverr,              // apb error
	input  wire logic                          synth_one_clock,      // first synthesizer clock
	input  wire logic                          synth_two_clock,      // second synthesizer clock
	input  wire logic                          master_clock_in,      // external master clock
	output logic      [23:0]                   synth_freq_word,      // synth_two frequency word
	output logic                               master_clock_out_one, // first codec clock
	output logic                               master_clock_out_two  // second codec clock
);

	amcc_pkg::amcc_state_t s;
	amcc_pkg::amcc_state_t next_s;

	logic [amcc_pkg::NUM_CH-1:0]      div_clk;
	logic [amcc_pkg::SYNTH_OUTPUT_DIVISOR_W-1:0]      divisor [amcc_pkg::NUM_CH];
	logic                             div_enable;
	logic [amcc_pkg::ADDR_W-1:0]      wr_addr;

	// byte address of a register index
	function automatic logic [amcc_pkg::ADDR_W-1:0] reg_addr
	(
		input logic [15:0] idx
	);
		reg_addr = {idx, 2'b00};
	endfunction : reg_addr

	// source selection, shared by both outputs
	function automatic logic pick_source
	(
		input logic [1:0]                  sel,
		input logic [amcc_pkg::NUM_CH-1:0] clks
	);
		if (sel[amcc_pkg::SEL_INPUT_BIT])
			pick_source = clks[amcc_pkg::CH_INPUT];
		else if (sel == amcc_pkg::SEL_SYNTH_TWO)
			pick_source = clks[amcc_pkg::CH_SYNTH_TWO];
		else
			pick_source = clks[amcc_pkg::CH_SYNTH_ONE];
	endfunction : pick_source

	// register read mux; unmapped addresses flag an error
	function automatic logic [8:0] read_reg
	(
		input logic [amcc_pkg::ADDR_W-1:0] addr,
		input amcc_pkg::amcc_regs_t        r,
		input logic [4:0]                  status
	);
		if (addr == reg_addr(amcc_pkg::IDX_OUT_CTL))
			read_reg = {1'b0, r.out_ctl};
		else if (addr == reg_addr(amcc_pkg::IDX_ONE_DIV))
			read_reg = {1'b0, r.one_div};
		else if (addr == reg_addr(amcc_pkg::IDX_TWO_DIV))
			read_reg = {1'b0, r.two_div};
		else if (addr == reg_addr(amcc_pkg::IDX_FREQ_HIGH))
			read_reg = {1'b0, r.freq_high};
		else if (addr == reg_addr(amcc_pkg::IDX_FREQ_MID))
			read_reg = {1'b0, r.freq_mid};
		else if (addr == reg_addr(amcc_pkg::IDX_FREQ_LOW))
			read_reg = {1'b0, r.freq_low};
		else if (addr == reg_addr(amcc_pkg::IDX_STATUS))
			read_reg = {4'h0, status};
		else
			read_reg = {1'b1, 8'h00};
	endfunction : read_reg

	assign div_enable = s.regs.out_ctl[amcc_pkg::DIV_EN_BIT];
	assign wr_addr = paddr;

	assign divisor[amcc_pkg::CH_SYNTH_ONE] =
		s.regs.one_div[amcc_pkg::SYNTH_OUTPUT_DIVISOR_LO +: amcc_pkg::SYNTH_OUTPUT_DIVISOR_W];
	assign divisor[amcc_pkg::CH_SYNTH_TWO] =
		s.regs.two_div[amcc_pkg::SYNTH_OUTPUT_DIVISOR_LO +: amcc_pkg::SYNTH_OUTPUT_DIVISOR_W];
	assign divisor[amcc_pkg::CH_INPUT] =
		{1'b0, s.regs.one_div[amcc_pkg::INPUT_CLOCK_DIVISOR_LO +: amcc_pkg::INPUT_CLOCK_DIVISOR_W]};

	// one divider per clock source, all gated by the shared enable
	generate
		for (genvar g = 0; g < amcc_pkg::NUM_CH; g++)
		begin : g_div
			amcc_divider u_div
			(
				.pclk    (pclk),
				.presetn (presetn),
				.src     (s.sync_b[g]),
				.enable  (div_enable),
				.divisor (divisor[g]),
				.clk_out (div_clk[g])
			);
		end
	endgenerate

	always_comb
	begin
		logic [8:0] rd;
		logic [4:0] status;
		logic       do_write;
		next_s = s;
		status = {div_clk, s.out_two, s.out_one};
		rd = read_reg(paddr, s.regs, status);
		do_write = psel && penable && pwrite && s.ready && pstrb[0];

		// outside clocks pass two flops before anything looks at them
		next_s.sync_a = {master_clock_in, synth_two_clock, synth_one_clock};
		next_s.sync_b = s.sync_a;

		// setup phase: capture the answer so the access phase sees it at once
		next_s.ready  = 1'b0;
		next_s.slverr = 1'b0;
		if (psel && !penable)
		begin
			next_s.ready  = 1'b1;
			next_s.slverr = rd[8];
			next_s.rdata  = pwrite ? '0 : {24'h000000, rd[7:0]};
		end
		else
		begin
			// read data stands only with ready, zero otherwise
			next_s.rdata = '0;
		end

		// write lands at the access edge on which ready is seen high
		if (do_write)
		begin
			if (wr_addr == reg_addr(amcc_pkg::IDX_OUT_CTL))
			begin
				next_s.regs.out_ctl = pwdata[7:0] & amcc_pkg::OUT_CTL_MASK;
			end
			else if (wr_addr == reg_addr(amcc_pkg::IDX_ONE_DIV))
			begin
				next_s.regs.one_div = pwdata[7:0] & amcc_pkg::ONE_DIV_MASK;
			end
			else if (wr_addr == reg_addr(amcc_pkg::IDX_TWO_DIV))
			begin
				next_s.regs.two_div = pwdata[7:0] & amcc_pkg::TWO_DIV_MASK;
			end
			else if (wr_addr == reg_addr(amcc_pkg::IDX_FREQ_HIGH))
			begin
				next_s.regs.freq_high = pwdata[7:0];
			end
			else if (wr_addr == reg_addr(amcc_pkg::IDX_FREQ_MID))
			begin
				next_s.regs.freq_mid = pwdata[7:0];
			end
			else if (wr_addr == reg_addr(amcc_pkg::IDX_FREQ_LOW))
			begin
				next_s.regs.freq_low = pwdata[7:0];
			end
		end

		// disabled outputs sit low so the codec never sees a runt edge source
		if (s.regs.out_ctl[amcc_pkg::OUT_ONE_EN_BIT])
		begin
			next_s.out_one = pick_source(
				s.regs.out_ctl[amcc_pkg::OUT_ONE_SEL_LO +: 2], div_clk);
		end
		else
		begin
			next_s.out_one = 1'b0;
		end
		if (s.regs.out_ctl[amcc_pkg::OUT_TWO_EN_BIT])
		begin
			next_s.out_two = pick_source(
				s.regs.out_ctl[amcc_pkg::OUT_TWO_SEL_LO +: 2], div_clk);
		end
		else
		begin
			next_s.out_two = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s                <= '0;
			s.regs.out_ctl   <= amcc_pkg::REG_RESET;
			s.regs.one_div   <= amcc_pkg::REG_RESET;
			s.regs.two_div   <= amcc_pkg::REG_RESET;
			s.regs.freq_high <= amcc_pkg::REG_RESET;
			s.regs.freq_mid  <= amcc_pkg::REG_RESET;
			s.regs.freq_low  <= amcc_pkg::REG_RESET;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign prdata  = s.rdata;
	assign pready  = s.ready;
	assign pslverr = s.slverr;

	// word handed to the second synthesizer
	assign synth_freq_word = {s.regs.freq_high, s.regs.freq_mid, s.regs.freq_low};

	assign master_clock_out_one = s.out_one;
	assign master_clock_out_two = s.out_two;

endmodule : amcc_core

`default_nettype wire

// file: verilog/amcc_divider.sv
// edge-counting clock divider driven from a synchronised source level
`timescale 1ns/1ps
`default_nettype none

module amcc_divider
(
	input  wire logic                         pclk,    // system clock
	input  wire logic                         presetn, // async reset, active low
	input  wire logic                         src,     // synchronised source clock level
	input  wire logic                         enable,  // divider enable
	input  wire logic [amcc_pkg::SYNTH_OUTPUT_DIVISOR_W-1:0]  divisor, // field value, divides by value+1
	output logic                              clk_out  // divided clock level
);

	amcc_pkg::amcc_div_state_t s;
	amcc_pkg::amcc_div_state_t next_s;
	logic [amcc_pkg::SYNTH_OUTPUT_DIVISOR_W-1:0] half;

	// source must run below half of pclk or edges are missed
	always_comb
	begin
		next_s = s;
		half = 4'((5'(divisor) + 5'd1) >> 1);
		next_s.prev = src;
		if (!enable)
		begin
			next_s.cnt = '0;
			next_s.out = 1'b0;
		end
		else
		begin
			if (src && !s.prev)
			begin
				if (s.cnt >= divisor)
					next_s.cnt = '0;
				else
					next_s.cnt = s.cnt + 4'h1;
			end
			if (divisor == '0)
				next_s.out = src;
			else
				next_s.out = (next_s.cnt < half);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign clk_out = s.out;

endmodule : amcc_divider

`default_nettype wire

// file: verilog/amcc_pkg.sv
// shared constants and types for the audio master clock control block
package amcc_pkg;

	// bus geometry: registers sit at byte address = index * 4
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;

	// register indices
	localparam logic [15:0] IDX_OUT_CTL   = 16'hffe1;
	localparam logic [15:0] IDX_ONE_DIV   = 16'hffe2;
	localparam logic [15:0] IDX_TWO_DIV   = 16'hfff6;
	localparam logic [15:0] IDX_FREQ_HIGH = 16'hfff7;
	localparam logic [15:0] IDX_FREQ_MID  = 16'hfff8;
	localparam logic [15:0] IDX_FREQ_LOW  = 16'hfff9;
	localparam logic [15:0] IDX_STATUS    = 16'hfff0;

	// reset value of every register
	localparam logic [7:0] REG_RESET = 8'h00;

	// writable bits; reserved bits are masked off and read as zero
	localparam logic [7:0] OUT_CTL_MASK = 8'hdf;
	localparam logic [7:0] ONE_DIV_MASK = 8'hf7;
	localparam logic [7:0] TWO_DIV_MASK = 8'hf0;

	// master_clock_output_control fields
	localparam int OUT_TWO_EN_BIT = 7;
	localparam int OUT_ONE_EN_BIT = 6;
	localparam int OUT_ONE_SEL_LO = 3;
	localparam int DIV_EN_BIT     = 2;
	localparam int OUT_TWO_SEL_LO = 0;

	// divider fields
	localparam int SYNTH_OUTPUT_DIVISOR_LO = 4;
	localparam int SYNTH_OUTPUT_DIVISOR_W  = 4;
	localparam int INPUT_CLOCK_DIVISOR_LO = 0;
	localparam int INPUT_CLOCK_DIVISOR_W  = 3;

	// source select codes; bit 0 set picks the input clock path
	localparam int SEL_INPUT_BIT = 0;
	localparam logic [1:0] SEL_SYNTH_ONE = 2'b00;
	localparam logic [1:0] SEL_SYNTH_TWO = 2'b10;

	// divider channels
	localparam int CH_SYNTH_ONE = 0;
	localparam int CH_SYNTH_TWO = 1;
	localparam int CH_INPUT     = 2;
	localparam int NUM_CH       = 3;

	typedef struct packed {
		logic [7:0] out_ctl;
		logic [7:0] one_div;
		logic [7:0] two_div;
		logic [7:0] freq_high;
		logic [7:0] freq_mid;
		logic [7:0] freq_low;
	} amcc_regs_t;

	typedef struct packed {
		amcc_regs_t       regs;
		logic             ready;
		logic             slverr;
		logic [DATA_W-1:0] rdata;
		logic [NUM_CH-1:0] sync_a;
		logic [NUM_CH-1:0] sync_b;
		logic             out_one;
		logic             out_two;
	} amcc_state_t;

	typedef struct packed {
		logic             prev;
		logic [SYNTH_OUTPUT_DIVISOR_W-1:0] cnt;
		logic             out;
	} amcc_div_state_t;

endpackage : amcc_pkg
